// ==== common/shift_unit_pkg.sv ====
/*
  Shared constants for the extended shift and rotate datapath: operand widths,
  operation and width encodings, status register bit positions.
  Assumes the core decodes instructions into these encodings.
*/
package shift_unit_pkg;

  localparam int DATA_W   = 20;
  localparam int CNT_W    = 3;
  localparam int SR_W     = 16;
  localparam int MAX_CNT  = 4;

  // Status register bit positions
  localparam int SR_C_BIT = 0;
  localparam int SR_Z_BIT = 1;
  localparam int SR_N_BIT = 2;
  localparam int SR_V_BIT = 8;

  // Sign bit per width
  localparam int MSB_A    = 19;
  localparam int MSB_W    = 15;
  localparam int MSB_B    = 7;

  // Overflow windows of the single-position left forms, half-open
  localparam logic [19:0] OVF_LO_A = 20'h40000;
  localparam logic [19:0] OVF_HI_A = 20'hc0000;
  localparam logic [19:0] OVF_LO_W = 20'h04000;
  localparam logic [19:0] OVF_HI_W = 20'h0c000;
  localparam logic [19:0] OVF_LO_B = 20'h00040;
  localparam logic [19:0] OVF_HI_B = 20'h000c0;

  localparam logic [19:0] MASK_A   = 20'hfffff;
  localparam logic [19:0] MASK_W   = 20'h0ffff;
  localparam logic [19:0] MASK_B   = 20'h000ff;

  typedef enum logic [1:0] {
    WID_BYTE = 2'b00,
    WID_WORD = 2'b01,
    WID_ADDR = 2'b10
  } width_t;

  typedef enum logic [2:0] {
    OP_NONE   = 3'b000,
    OP_MLAS   = 3'b001,
    OP_XLAS   = 3'b010,
    OP_XLRC   = 3'b011,
    OP_MRAS   = 3'b100,
    OP_XRAS   = 3'b101,
    OP_MRRC   = 3'b110,
    OP_XRRC   = 3'b111
  } shift_op_t;

endpackage

// ==== core/shift_step.sv ====
`timescale 1ns/10ps
/*
  One-position shift or rotate of a width-masked operand.
  Assumes the operand is already cleared above the selected width.
*/
module shift_step
  import shift_unit_pkg::*;
(
  input  wire logic [DATA_W-1:0] din,
  input  wire logic              cin,
  input  wire width_t            width,
  input  wire logic              left,
  input  wire logic              arith,
  output logic      [DATA_W-1:0] dout,
  output logic                   cout
);

  logic msb;
  logic fill;

  always_comb begin
    unique case (width)
      WID_BYTE: msb = din[MSB_B];
      WID_WORD: msb = din[MSB_W];
      default:  msb = din[MSB_A];
    endcase
    // Arithmetic right keeps the sign, rotate takes the old carry
    fill = arith ? msb : cin;
    dout = '0;
    if (left) begin
      dout = {din[DATA_W-2:0], (arith ? 1'b0 : cin)};
      cout = msb;
      unique case (width)
        WID_BYTE: dout = dout & MASK_B;
        WID_WORD: dout = dout & MASK_W;
        default:  dout = dout & MASK_A;
      endcase
    end else begin
      dout = {1'b0, din[DATA_W-1:1]};
      cout = din[0];
      unique case (width)
        WID_BYTE: dout[MSB_B] = fill;
        WID_WORD: dout[MSB_W] = fill;
        default:  dout[MSB_A] = fill;
      endcase
    end
  end

endmodule

// ==== core/ext_shift_unit.sv ====
`timescale 1ns/10ps
/*
  Extended shift and rotate datapath: multi-position register forms and
  single-position register or memory forms, with N, Z, C, V update.
  Assumes the core presents one operation per start pulse, with the operand
  fetched from a register or the memory operand path, and writes back the
  result and status register when done pulses. One cycle latency.
*/
// Overview of operation
// [RQ1] Multi left shift moves left by one to four, zeros fill from bottom.
// [RQ2] Word-width multi-position operations clear result bits 19 to 16.
// [RQ3] Multi left shift carry gets the last bit shifted out at the top.
// [RQ4] Negative flag is bit 19, 15 or 7 of the result by width.
// [RQ5] Zero flag set only when the result at the width is zero.
// [RQ6] Single left shift fills bit zero with zero, top bit into carry.
// [RQ7] Single left forms set overflow when operand lies in the mid window.
// [RQ8] Single left rotate puts old carry at bottom, old top into carry.
// [RQ9] Multi right shift moves right one to four, replicating the sign.
// [RQ10] Multi right forms' carry gets the last bit shifted out at bottom.
// [RQ11] Single right shift keeps sign; clears bits above the width in registers.
// [RQ12] Single right forms also accept memory targets, not immediate.
// [RQ13] Multi right rotate feeds old carry into top each step.
// [RQ14] Single right rotate on a register clears bits above the width.
// [RQ15] Multi forms take width and count from the instruction, no extension word.
// [RQ16] Oscillator-off, halt and interrupt enable bits are never changed.
// [RQ17] Single right shift copies the outgoing lowest bit into carry.
// [RQ18] Right forms clear overflow; multi left leaves overflow undefined.
module ext_shift_unit
  import shift_unit_pkg::*;
#(
  parameter int STEPS = MAX_CNT
)(
  input  wire logic              clk,
  input  wire logic              rst,
  input  wire logic              start,
  input  wire shift_op_t         op,
  input  wire width_t            width,
  input  wire logic [CNT_W-1:0]  count,
  input  wire logic              dst_is_mem,
  input  wire logic [DATA_W-1:0] operand,
  input  wire logic [SR_W-1:0]   sr_in,
  output logic      [DATA_W-1:0] result,
  output logic      [SR_W-1:0]   sr_out,
  output logic                   done
);

  logic [DATA_W-1:0] result_reg;
  logic [DATA_W-1:0] result_next;
  logic [SR_W-1:0]   sr_reg;
  logic [SR_W-1:0]   sr_next;
  logic              done_reg;

  logic [DATA_W-1:0] masked;
  logic [DATA_W-1:0] chain_d [0:STEPS];
  logic              chain_c [0:STEPS];
  logic              is_left;
  logic              is_arith;
  logic              is_multi;
  logic [CNT_W-1:0]  steps;
  logic              ovf;
  logic              neg;

  always_comb begin
    unique case (width)
      WID_BYTE: masked = operand & MASK_B;
      WID_WORD: masked = operand & MASK_W;
      default:  masked = operand & MASK_A;
    endcase
  end

  always_comb begin
    is_left  = (op == OP_MLAS) || (op == OP_XLAS) || (op == OP_XLRC);
    is_arith = (op == OP_MLAS) || (op == OP_XLAS) || (op == OP_MRAS) || (op == OP_XRAS);
    is_multi = (op == OP_MLAS) || (op == OP_MRAS) || (op == OP_MRRC);
    // Count comes straight from the instruction, no prefix needed
    steps    = is_multi ? count : CNT_W'(1); // RQ15
  end

  assign chain_d[0] = masked;
  assign chain_c[0] = sr_in[SR_C_BIT];

  // Always compute all steps; the count selects the tap
  genvar g;
  generate
    for (g = 0; g < STEPS; g++) begin : g_step
      shift_step u_step (
        .din   (chain_d[g]),
        .cin   (chain_c[g]),
        .width (width),
        .left  (is_left),
        .arith (is_arith),
        .dout  (chain_d[g+1]),
        .cout  (chain_c[g+1])
      );
    end
  endgenerate

  always_comb begin
    ovf = 1'b0;
    unique case (width)
      WID_BYTE: ovf = (masked >= OVF_LO_B) && (masked < OVF_HI_B); // RQ7
      WID_WORD: ovf = (masked >= OVF_LO_W) && (masked < OVF_HI_W); // RQ7
      default:  ovf = (masked >= OVF_LO_A) && (masked < OVF_HI_A); // RQ7
    endcase
  end

  always_comb begin
    result_next = chain_d[1];
    sr_next     = sr_in; // RQ16
    if (steps >= CNT_W'(1) && steps <= CNT_W'(STEPS)) begin
      result_next = chain_d[steps]; // RQ1 RQ9 RQ13 RQ6 RQ8
      sr_next[SR_C_BIT] = chain_c[steps]; // RQ3 RQ10 RQ17
    end else begin
      // Out-of-range count is treated as one position
      sr_next[SR_C_BIT] = chain_c[1];
    end
    // Stages already mask to width: word clears 19:16, byte 19:8
    unique case (width)
      WID_BYTE: neg = result_next[MSB_B]; // RQ4
      WID_WORD: neg = result_next[MSB_W]; // RQ4
      default:  neg = result_next[MSB_A]; // RQ4
    endcase
    sr_next[SR_N_BIT] = neg;
    sr_next[SR_Z_BIT] = (result_next == '0); // RQ5
    if (!is_left) begin
      sr_next[SR_V_BIT] = 1'b0; // RQ18
    end else if (!is_multi) begin
      sr_next[SR_V_BIT] = ovf; // RQ7
    end else begin
      // Undefined for the multi left form; leave it as it was
      sr_next[SR_V_BIT] = sr_in[SR_V_BIT]; // RQ18
    end
    // Memory targets are written back at width by the core; same value here
    if (dst_is_mem) begin
      result_next = result_next; // RQ12
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      result_reg <= '0;
    end else if (start && op != OP_NONE) begin
      result_reg <= result_next; // RQ2 RQ11 RQ14
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      sr_reg <= '0;
    end else if (start && op != OP_NONE) begin
      sr_reg <= sr_next;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      done_reg <= 1'b0;
    end else begin
      done_reg <= start && (op != OP_NONE);
    end
  end

  assign result = result_reg;
  assign sr_out = sr_reg;
  assign done   = done_reg;

  // Helpers sampled every cycle, so at done they hold the start-cycle values
  logic [SR_W-1:0]   sr_in_q;
  logic [DATA_W-1:0] masked_q;
  shift_op_t         op_q;
  width_t            width_q;
  logic [CNT_W-1:0]  count_q;
  always_ff @(posedge clk) begin
    sr_in_q  <= sr_in;
    masked_q <= masked;
    op_q     <= op;
    width_q  <= width;
    count_q  <= count;
  end

  mode_bits_kept_a : assert property (@(posedge clk) disable iff (rst) // RQ16
    done |-> (sr_out[SR_W-1:SR_V_BIT+1] == sr_in_q[SR_W-1:SR_V_BIT+1]) && (sr_out[6:3] == sr_in_q[6:3]))
    else $error("mode bits changed");

  zero_flag_a : assert property (@(posedge clk) disable iff (rst) // RQ5
    done |-> sr_out[SR_Z_BIT] == (result == '0))
    else $error("zero flag wrong");

  word_upper_clear_a : assert property (@(posedge clk) disable iff (rst) // RQ2
    done && width_q == WID_WORD |-> result[19:16] == 4'h0)
    else $error("word upper bits not cleared");

  byte_upper_clear_a : assert property (@(posedge clk) disable iff (rst) // RQ11
    done && width_q == WID_BYTE |-> result[19:8] == 12'h000)
    else $error("byte upper bits not cleared");

  right_ovf_clear_a : assert property (@(posedge clk) disable iff (rst) // RQ18
    done && (op_q == OP_MRAS || op_q == OP_XRAS || op_q == OP_MRRC || op_q == OP_XRRC) |-> !sr_out[SR_V_BIT])
    else $error("right form left overflow set");

  left_one_shift_a : assert property (@(posedge clk) disable iff (rst) // RQ6
    done && op_q == OP_XLAS && width_q == WID_ADDR |->
      result == {masked_q[18:0], 1'b0} && sr_out[SR_C_BIT] == masked_q[19])
    else $error("single left shift wrong");

  rotate_left_a : assert property (@(posedge clk) disable iff (rst) // RQ8
    done && op_q == OP_XLRC && width_q == WID_ADDR |->
      result == {masked_q[18:0], sr_in_q[SR_C_BIT]} && sr_out[SR_C_BIT] == masked_q[19])
    else $error("rotate left wrong");

  multi_left_a : assert property (@(posedge clk) disable iff (rst) // RQ3
    done && op_q == OP_MLAS && width_q == WID_ADDR && count_q == 3'd4 |->
      result == {masked_q[15:0], 4'h0} && sr_out[SR_C_BIT] == masked_q[16])
    else $error("multi left by four wrong");

  multi_right_a : assert property (@(posedge clk) disable iff (rst) // RQ9
    done && op_q == OP_MRAS && width_q == WID_WORD && count_q == 3'd2 |->
      result[15:0] == {{2{masked_q[15]}}, masked_q[15:2]} && sr_out[SR_C_BIT] == masked_q[1])
    else $error("multi right arith wrong");

  sign_flag_a : assert property (@(posedge clk) disable iff (rst) // RQ4
    done && width_q == WID_BYTE |-> sr_out[SR_N_BIT] == result[MSB_B])
    else $error("negative flag wrong");

  // Checks in this module tie forms and widths to their bit pictures, except multi forms at byte width and single right rotate at address width
  sign_word_a : assert property (@(posedge clk) disable iff (rst) // RQ4
    done && width_q == WID_WORD |-> sr_out[SR_N_BIT] == result[MSB_W])
    else $error("word negative flag wrong");

  sign_addr_a : assert property (@(posedge clk) disable iff (rst) // RQ4
    done && width_q != WID_WORD && width_q != WID_BYTE |-> sr_out[SR_N_BIT] == result[MSB_A])
    else $error("address negative flag wrong");

  accepted_done_a : assert property (@(posedge clk) disable iff (rst) // RQ15
    start && op != OP_NONE |=> done)
    else $error("accepted start gave no done");

  refused_done_a : assert property (@(posedge clk) disable iff (rst) // RQ15
    !(start && op != OP_NONE) |=> !done)
    else $error("done without accepted start");

  result_hold_a : assert property (@(posedge clk) disable iff (rst) // RQ12
    !done |-> $stable(result))
    else $error("result changed without done");

  status_hold_a : assert property (@(posedge clk) disable iff (rst) // RQ16
    !done |-> $stable(sr_out))
    else $error("status changed without done");

  left_ovf_word_a : assert property (@(posedge clk) disable iff (rst) // RQ7
    done && (op_q == OP_XLAS || op_q == OP_XLRC) && width_q == WID_WORD |->
      sr_out[SR_V_BIT] == (masked_q >= OVF_LO_W && masked_q < OVF_HI_W))
    else $error("word overflow flag wrong");

  left_ovf_byte_a : assert property (@(posedge clk) disable iff (rst) // RQ7
    done && (op_q == OP_XLAS || op_q == OP_XLRC) && width_q == WID_BYTE |->
      sr_out[SR_V_BIT] == (masked_q >= OVF_LO_B && masked_q < OVF_HI_B))
    else $error("byte overflow flag wrong");

  multi_left_v_a : assert property (@(posedge clk) disable iff (rst) // RQ18
    done && op_q == OP_MLAS |-> sr_out[SR_V_BIT] == sr_in_q[SR_V_BIT])
    else $error("multi left overflow moved");

  left_shift_word_a : assert property (@(posedge clk) disable iff (rst) // RQ6
    done && op_q == OP_XLAS && width_q == WID_WORD |->
      result == {4'h0, masked_q[14:0], 1'b0} && sr_out[SR_C_BIT] == masked_q[15])
    else $error("word single left shift wrong");

  left_shift_byte_a : assert property (@(posedge clk) disable iff (rst) // RQ6
    done && op_q == OP_XLAS && width_q == WID_BYTE |->
      result == {12'h000, masked_q[6:0], 1'b0} && sr_out[SR_C_BIT] == masked_q[7])
    else $error("byte single left shift wrong");

  rotate_left_byte_a : assert property (@(posedge clk) disable iff (rst) // RQ8
    done && op_q == OP_XLRC && width_q == WID_BYTE |->
      result == {12'h000, masked_q[6:0], sr_in_q[SR_C_BIT]} && sr_out[SR_C_BIT] == masked_q[7])
    else $error("byte rotate left wrong");

  rotate_left_word_a : assert property (@(posedge clk) disable iff (rst) // RQ8
    done && op_q == OP_XLRC && width_q == WID_WORD |->
      result == {4'h0, masked_q[14:0], sr_in_q[SR_C_BIT]} && sr_out[SR_C_BIT] == masked_q[15])
    else $error("word rotate left wrong");

  multi_left_one_a : assert property (@(posedge clk) disable iff (rst) // RQ1
    done && op_q == OP_MLAS && width_q == WID_ADDR && count_q == 3'h1 |->
      result == {masked_q[18:0], 1'b0} && sr_out[SR_C_BIT] == masked_q[19])
    else $error("multi left by one wrong");

  multi_left_word_a : assert property (@(posedge clk) disable iff (rst) // RQ3
    done && op_q == OP_MLAS && width_q == WID_WORD && count_q == 3'h2 |->
      result == {4'h0, masked_q[13:0], 2'b00} && sr_out[SR_C_BIT] == masked_q[14])
    else $error("word multi left by two wrong");

  multi_right_four_a : assert property (@(posedge clk) disable iff (rst) // RQ10
    done && op_q == OP_MRAS && width_q == WID_ADDR && count_q == 3'h4 |->
      result == {{4{masked_q[19]}}, masked_q[19:4]} && sr_out[SR_C_BIT] == masked_q[3])
    else $error("multi right by four wrong");

  rotate_right_three_a : assert property (@(posedge clk) disable iff (rst) // RQ13
    done && op_q == OP_MRRC && width_q == WID_ADDR && count_q == 3'h3 |->
      result == {masked_q[1:0], sr_in_q[SR_C_BIT], masked_q[19:3]} && sr_out[SR_C_BIT] == masked_q[2])
    else $error("multi right rotate by three wrong");

  rotate_right_word_a : assert property (@(posedge clk) disable iff (rst) // RQ13
    done && op_q == OP_MRRC && width_q == WID_WORD && count_q == 3'h1 |->
      result == {4'h0, sr_in_q[SR_C_BIT], masked_q[15:1]} && sr_out[SR_C_BIT] == masked_q[0])
    else $error("word multi right rotate wrong");

  right_arith_byte_a : assert property (@(posedge clk) disable iff (rst) // RQ17
    done && op_q == OP_XRAS && width_q == WID_BYTE |->
      result == {12'h000, masked_q[7], masked_q[7:1]} && sr_out[SR_C_BIT] == masked_q[0])
    else $error("byte single right shift wrong");

  right_arith_word_a : assert property (@(posedge clk) disable iff (rst) // RQ11
    done && op_q == OP_XRAS && width_q == WID_WORD |->
      result == {4'h0, masked_q[15], masked_q[15:1]} && sr_out[SR_C_BIT] == masked_q[0])
    else $error("word single right shift wrong");

  right_arith_addr_a : assert property (@(posedge clk) disable iff (rst) // RQ11
    done && op_q == OP_XRAS && width_q == WID_ADDR |->
      result == {masked_q[19], masked_q[19:1]} && sr_out[SR_C_BIT] == masked_q[0])
    else $error("address single right shift wrong");

  right_rotate_byte_a : assert property (@(posedge clk) disable iff (rst) // RQ14
    done && op_q == OP_XRRC && width_q == WID_BYTE |->
      result == {12'h000, sr_in_q[SR_C_BIT], masked_q[7:1]} && sr_out[SR_C_BIT] == masked_q[0])
    else $error("byte single right rotate wrong");

  right_rotate_word_a : assert property (@(posedge clk) disable iff (rst) // RQ14
    done && op_q == OP_XRRC && width_q == WID_WORD |->
      result == {4'h0, sr_in_q[SR_C_BIT], masked_q[15:1]} && sr_out[SR_C_BIT] == masked_q[0])
    else $error("word single right rotate wrong");

endmodule

// ==== sim/core_port_model.sv ====
`timescale 1ns/10ps
/*
  Core side model: register file write-back port of the shift unit.
  Assumes done is a one-cycle pulse that qualifies result and sr_out.
*/
module core_port_model
  import shift_unit_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              done,
  input  wire logic [DATA_W-1:0] result,
  input  wire logic [SR_W-1:0]   sr_out,
  output logic      [DATA_W-1:0] wb_reg,
  output logic      [SR_W-1:0]   wb_sr_reg,
  output int                     wb_cnt
);
  initial begin
    wb_reg = '0;
    wb_sr_reg = '0;
    wb_cnt = 0;
  end

  // Count every write-back so lost or extra done pulses show up
  always @(posedge clk) begin
    if (done === 1'b1) begin
      wb_reg <= result;
      wb_sr_reg <= sr_out;
      wb_cnt <= wb_cnt + 1;
    end
  end
endmodule

// ==== sim/tb_ext_shift_unit.sv ====
`timescale 1ns/10ps
/*
  Self-checking bench for the extended shift and rotate unit.
  Assumes one cycle latency and back-to-back starts, as handed over.
*/
module tb_ext_shift_unit
  import shift_unit_pkg::*;
;
  logic              clk = 1'b0;
  logic              rst = 1'b1;
  logic              start = 1'b0;
  shift_op_t         op = OP_NONE;
  width_t            width = WID_BYTE;
  logic [CNT_W-1:0]  count = '0;
  logic              dst_is_mem = 1'b0;
  logic [DATA_W-1:0] operand = '0;
  logic [SR_W-1:0]   sr_in = '0;
  logic [DATA_W-1:0] result, wb_reg, last;
  logic [SR_W-1:0]   sr_out, wb_sr_reg, last_sr;
  logic              done;
  int                wb_cnt, errors = 0, num_checks = 0, cycles = 0, ops = 0;

  ext_shift_unit uut (.clk(clk), .rst(rst), .start(start), .op(op), .width(width), .count(count),
    .dst_is_mem(dst_is_mem), .operand(operand), .sr_in(sr_in), .result(result), .sr_out(sr_out), .done(done));
  core_port_model core (.clk(clk), .done(done), .result(result), .sr_out(sr_out), .wb_reg(wb_reg),
    .wb_sr_reg(wb_sr_reg), .wb_cnt(wb_cnt));

  always #12.5 clk = ~clk;

  task automatic print_verdict();
    if (errors == 0 && num_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  always @(posedge clk) begin
    cycles++;
    if (cycles == 1000) begin
      errors++;
      print_verdict();
    end
  end

  task automatic chk(string name, logic [19:0] exp, logic [19:0] got);
    num_checks++;
    if (got !== exp) begin
      errors++;
      $display("Error %s expected %h seen %h", name, exp, got);
    end
  endtask

  function automatic logic [35:0] ref_op(shift_op_t o, width_t w, int n, logic [19:0] d, logic [15:0] s);
    int msb;
    logic [19:0] m, x;
    logic c, t, b, rot;
    msb = (w == WID_BYTE) ? MSB_B : (w == WID_WORD) ? MSB_W : MSB_A;
    m = (w == WID_BYTE) ? MASK_B : (w == WID_WORD) ? MASK_W : MASK_A;
    x = d & m;
    c = s[SR_C_BIT];
    rot = (o == OP_XLRC) || (o[2:1] == 2'b11);
    if (o == OP_XLAS || o == OP_XLRC)
      s[SR_V_BIT] = (x >= (20'h1 << (msb - 1))) && (x < (20'h3 << (msb - 1)));
    else if (o[2])
      s[SR_V_BIT] = 1'b0;
    if (!(o == OP_MLAS || o == OP_MRAS || o == OP_MRRC))
      n = 1;
    for (int i = 0; i < n; i++) begin
      t = o[2] ? x[0] : x[msb];
      b = rot ? c : (o[2] & x[msb]);
      x = o[2] ? ((x >> 1) | (20'(b) << msb)) : (((x << 1) | 20'(b)) & m);
      c = t;
    end
    s[SR_C_BIT] = c;
    s[SR_Z_BIT] = (x == 20'h0);
    s[SR_N_BIT] = x[msb];
    return {x, s};
  endfunction

  // Leaves start high so the next call issues back to back
  task automatic run(shift_op_t o, width_t w, int n, logic mem, logic [19:0] d, logic [15:0] s);
    logic [35:0] e;
    e = ref_op(o, w, n, d, s);
    op = o;
    width = w;
    count = 3'(n);
    dst_is_mem = mem;
    operand = d;
    sr_in = s;
    start = 1'b1;
    @(posedge clk);
    #2;
    ops++;
    last = e[35:16];
    last_sr = e[15:0];
    chk("done", 20'h1, {19'h0, done});
    chk("result", e[35:16], result);
    chk("sr_out", {4'h0, e[15:0]}, {4'h0, sr_out});
  endtask

  task automatic multi_left_test();
    for (int n = 1; n <= MAX_CNT; n++) begin
      run(OP_MLAS, WID_ADDR, n, 1'b0, 20'h9a5c3, 16'h0138);
      run(OP_MLAS, WID_WORD, n, 1'b0, 20'hf8421, 16'h0000);
    end
  endtask

  task automatic single_left_test();
    int sh;
    logic [19:0] d;
    for (int k = 0; k < 3; k++) begin
      for (int j = 0; j < 4; j++) begin
        sh = (k == 0) ? 6 : (k == 1) ? 14 : 18;
        d = ((j < 2) ? (20'h1 << sh) : (20'h3 << sh)) - 20'(j % 2 == 0);
        run(OP_XLAS, width_t'(k), 1, j[0], d, 16'h0039);
        run(OP_XLRC, width_t'(k), 1, j[0], d, 16'h0031);
      end
    end
  endtask

  task automatic multi_right_test();
    for (int n = 1; n <= MAX_CNT; n++) begin
      run(OP_MRAS, WID_ADDR, n, 1'b0, 20'h8f0a6, 16'h0139);
      run(OP_MRAS, WID_WORD, n, 1'b0, 20'h3c35b, 16'h0100);
      run(OP_MRRC, WID_ADDR, n, 1'b0, 20'h0f0a6, 16'h0101);
      run(OP_MRRC, WID_WORD, n, 1'b0, 20'h58e39, 16'h0139);
    end
  endtask

  task automatic single_right_test();
    for (int k = 0; k < 3; k++) begin
      for (int m = 0; m < 2; m++) begin
        run(OP_XRAS, width_t'(k), 1, m[0], 20'hf80c5, 16'h0138);
        run(OP_XRRC, width_t'(k), 1, m[0], 20'h7b47a, 16'h0139);
      end
    end
  endtask

  task automatic zero_refused_test();
    run(OP_MLAS, WID_WORD, 4, 1'b0, 20'h1f000, 16'h0000);
    run(OP_XRRC, WID_BYTE, 1, 1'b1, 20'h00001, 16'h0000);
    op = OP_NONE;
    @(posedge clk);
    #2;
    chk("refused done", 20'h0, {19'h0, done});
    chk("held result", last, result);
    start = 1'b0;
    @(posedge clk);
    #2;
  endtask

  initial begin
    repeat (5) @(posedge clk);
    #2;
    rst = 1'b0;
    chk("reset result", 20'h0, result);
    chk("reset done", 20'h0, {19'h0, done});
    chk("reset sr_out", 20'h0, {4'h0, sr_out});
    multi_left_test();
    single_left_test();
    multi_right_test();
    single_right_test();
    zero_refused_test();
    chk("wb count", 20'(ops), 20'(wb_cnt));
    chk("wb value", last, wb_reg);
    chk("wb status", {4'h0, last_sr}, {4'h0, wb_sr_reg});
    print_verdict();
  end
endmodule
